// ==== verilog/eeprom_pkg.sv ====
// Purpose: shared constants and types for the serial eeprom access block
// Assumes: core clock mclk at 25 MHz, link clock is the host serial clock
// Notes: array is 32 bytes; x16 organisation pairs two bytes per word
`default_nettype none

package eeprom_pkg;

   // =====================================================================
   // array geometry
   localparam int MEM_BYTES = 32;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int FIFO_DEPTH = 4;

   // =====================================================================
   // op-code fields, first two bits then the full four
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_ERASE = 2'h3;
   localparam logic [3:0] OPC_ENABLE = 4'h3;
   localparam logic [3:0] OPC_CLEAR = 4'h2;
   localparam logic [3:0] OPC_FILL = 4'h1;

   // =====================================================================
   // bit counts after the start bit
   localparam logic [4:0] HDR_BITS_WIDE = 5'h08;
   localparam logic [4:0] HDR_BITS_BYTE = 5'h09;
   localparam logic [4:0] DATA_BITS_WIDE = 5'h10;
   localparam logic [4:0] DATA_BITS_BYTE = 5'h08;

   // =====================================================================
   // programming time
   localparam int PROG_TIME_NS = 10_000_000;
   localparam int MCLK_PERIOD_NS = 40;
   localparam int PROG_CYCLES = PROG_TIME_NS / MCLK_PERIOD_NS;
   localparam int TIMER_W = 18;

   // =====================================================================
   // types
   typedef enum logic [2:0] {
      OP_WRITE = 3'h0,
      OP_ERASE = 3'h1,
      OP_ENABLE = 3'h2,
      OP_DISABLE = 3'h3,
      OP_CLEAR_ALL = 3'h4,
      OP_FILL_ALL = 3'h5
   } cmd_op_type;

   typedef struct packed {
      cmd_op_type op;
      logic wide;
      logic [4:0] addr;
      logic [15:0] data;
   } cmd_type;

   typedef enum logic [2:0] {
      CORE_IDLE = 3'b001,
      CORE_ARM = 3'b010,
      CORE_PROG = 3'b100
   } core_state_type;

   typedef enum logic [4:0] {
      LINK_IDLE = 5'b00001,
      LINK_HEAD = 5'b00010,
      LINK_DATA = 5'b00100,
      LINK_READ = 5'b01000,
      LINK_DONE = 5'b10000
   } link_state_type;

endpackage

`default_nettype wire

// ==== verilog/serial_eeprom_256bit_access.sv ====
// Purpose: serial instruction decoder, self-timed programming and array
// Assumes: sel and din change away from rising sclk edges
// Notes: link logic runs on sclk; all of it but the synchronisers is cleared while sel is low;
//        commands cross to mclk through a dual-clock fifo
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// dual-clock command fifo, gray-coded pointers
module cmd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic wr_clk,
   input wire logic wr_clear,
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_clk,
   input wire logic rd_clear,
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
   logic [AW:0] rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
   logic [AW:0] wbin_d, rbin_d;
   logic push, pop;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   assign push = wr_valid && wr_ready;
   assign pop = rd_valid && rd_ready;
   assign wbin_d = wbin_q + {{AW{1'b0}}, 1'b1};
   assign rbin_d = rbin_q + {{AW{1'b0}}, 1'b1};
   assign wr_ready = wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
   assign rd_valid = rgray_q != wg_s2_q;
   assign rd_data = mem_q[rbin_q[AW-1:0]];

   // write clock may stop, so its side clears without it
   always_ff @(posedge wr_clk or posedge wr_clear) begin
      if (wr_clear) begin
         wbin_q <= '0;
         wgray_q <= '0;
      end else if (push) begin
         wbin_q <= wbin_d;
         wgray_q <= to_gray(wbin_d);
      end
   end

   always_ff @(posedge wr_clk or posedge wr_clear) begin
      if (wr_clear) begin
         rg_s1_q <= '0;
         rg_s2_q <= '0;
      end else begin
         rg_s1_q <= rgray_q;
         rg_s2_q <= rg_s1_q;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem_q[wbin_q[AW-1:0]] <= wr_data;
      end
   end

   always_ff @(posedge rd_clk) begin
      if (rd_clear) begin
         rbin_q <= '0;
         rgray_q <= '0;
         wg_s1_q <= '0;
         wg_s2_q <= '0;
      end else begin
         wg_s1_q <= wgray_q;
         wg_s2_q <= wg_s1_q;
         if (pop) begin
            rbin_q <= rbin_d;
            rgray_q <= to_gray(rbin_d);
         end
      end
   end
endmodule

// What this block does
// - org pin picks 32x8 or 16x16
// - decode read, write, erase, clear, fill
// - read loads address into pointer
// - shift location out, then bump pointer
// - keep streaming while select stays high
// - pointer wraps from top to zero
// - programming timed internally, clock independent
// - write needs no prior erase
// - one write programs exactly one location
// - busy or ready on output from the first sclk edge of a frame
// - four op bits, then 4/5 address bits
// - first one after the first edge, while ready, is start bit
// - dummy zero, then data msb first
// - programming disabled until enable command
module serial_eeprom_256bit_access
   import eeprom_pkg::*;
#(
   parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic sel,
   input wire logic din,
   input wire logic org_wide,
   output logic q_out,
   output logic q_oe
);
   // =====================================================================
   // core domain state
   logic sel_s1_q, sel_s2_q;
   core_state_type core_state_q;
   cmd_type cmd_q;
   logic prog_en_q;
   logic busy_q;
   logic [TIMER_W-1:0] timer_q;
   logic [7:0] mem_q [MEM_BYTES];
   cmd_type rd_cmd;
   logic rd_valid, rd_ready, pop, prog_end;

   // =====================================================================
   // link domain state
   link_state_type link_state_q;
   logic busy_l1_q, busy_l2_q, org_l1_q, org_l2_q;
   logic skip_q;
   logic [4:0] cnt_q;
   logic [15:0] sh_q;
   logic [4:0] addr_q;
   cmd_op_type op_q;
   logic [8:0] hdr_full;
   logic [15:0] data_full, rd_word;
   logic [3:0] op_full;
   logic [4:0] addr_full, addr_nxt, rd_addr, data_len;
   cmd_op_type cmd_op;
   logic needs_data, is_read, hdr_last, data_last, wide_l;
   cmd_type wr_cmd;
   logic wr_valid;

   // =====================================================================
   // command crossing
   cmd_fifo #(.WIDTH($bits(cmd_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wr_clk(sclk),
      .wr_clear(reset),
      .wr_valid(wr_valid),
      .wr_data(wr_cmd),
      .wr_ready(),
      .rd_clk(mclk),
      .rd_clear(reset),
      .rd_valid(rd_valid),
      .rd_data(rd_cmd),
      .rd_ready(rd_ready)
   );

   // =====================================================================
   // core: select sync, command execution, timer
   always_ff @(posedge mclk) begin
      if (reset) begin
         sel_s1_q <= 1'b0;
         sel_s2_q <= 1'b0;
      end else begin
         sel_s1_q <= sel;
         sel_s2_q <= sel_s1_q;
      end
   end

   // stall draining while a cycle runs
   assign rd_ready = core_state_q == CORE_IDLE;
   assign pop = rd_valid && rd_ready;
   assign prog_end = core_state_q == CORE_PROG && timer_q == '0;

   always_ff @(posedge mclk) begin
      if (reset) begin
         core_state_q <= CORE_IDLE;
      end else begin
         case (core_state_q)
            CORE_IDLE: begin
               if (pop && prog_en_q && rd_cmd.op != OP_ENABLE &&
                   rd_cmd.op != OP_DISABLE) begin
                  core_state_q <= CORE_ARM;
               end
            end
            // cycle starts when select falls
            CORE_ARM: begin
               if (!sel_s2_q) begin
                  core_state_q <= CORE_PROG;
               end
            end
            CORE_PROG: begin
               if (prog_end) begin
                  core_state_q <= CORE_IDLE;
               end
            end
            default: core_state_q <= CORE_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cmd_q <= '0;
      end else if (pop) begin
         cmd_q <= rd_cmd;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         prog_en_q <= 1'b0;
      end else if (pop && rd_cmd.op == OP_ENABLE) begin
         prog_en_q <= 1'b1;
      end else if (pop && rd_cmd.op == OP_DISABLE) begin
         prog_en_q <= 1'b0;
      end
   end

   // counts on mclk only, sclk may stop
   always_ff @(posedge mclk) begin
      if (reset) begin
         timer_q <= '0;
      end else if (core_state_q == CORE_ARM && !sel_s2_q) begin
         timer_q <= TIMER_W'(PROG_CYCLES_P - 1);
      end else if (core_state_q == CORE_PROG && timer_q != '0) begin
         timer_q <= timer_q - {{(TIMER_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= core_state_q != CORE_IDLE || pop;
      end
   end

   // array changes only at cycle end, while link sees busy
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem_q[i] <= ERASED_BYTE;
         end
      end else if (prog_end) begin
         case (cmd_q.op)
            OP_WRITE: begin
               // overwrite directly, no erase step needed
               if (cmd_q.wide) begin
                  mem_q[{cmd_q.addr[3:0], 1'b1}] <= cmd_q.data[15:8];
                  mem_q[{cmd_q.addr[3:0], 1'b0}] <= cmd_q.data[7:0];
               end else begin
                  mem_q[cmd_q.addr] <= cmd_q.data[7:0];
               end
            end
            OP_ERASE: begin
               if (cmd_q.wide) begin
                  mem_q[{cmd_q.addr[3:0], 1'b1}] <= ERASED_BYTE;
                  mem_q[{cmd_q.addr[3:0], 1'b0}] <= ERASED_BYTE;
               end else begin
                  mem_q[cmd_q.addr] <= ERASED_BYTE;
               end
            end
            OP_CLEAR_ALL: begin
               for (int i = 0; i < MEM_BYTES; i++) begin
                  mem_q[i] <= ERASED_BYTE;
               end
            end
            OP_FILL_ALL: begin
               for (int i = 0; i < MEM_BYTES; i++) begin
                  mem_q[i] <= (cmd_q.wide && i[0]) ? cmd_q.data[15:8] :
                              cmd_q.data[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   // =====================================================================
   // link: synchronisers
   // cleared by reset so the first frame sees defined levels
   always_ff @(posedge sclk or posedge reset) begin
      if (reset) begin
         busy_l1_q <= 1'b0;
         busy_l2_q <= 1'b0;
         org_l1_q <= 1'b0;
         org_l2_q <= 1'b0;
      end else begin
         busy_l1_q <= busy_q;
         busy_l2_q <= busy_l1_q;
         org_l1_q <= org_wide;
         org_l2_q <= org_l1_q;
      end
   end

   // =====================================================================
   // link: decode
   assign wide_l = org_l2_q;
   assign hdr_full = {sh_q[7:0], din};
   assign op_full = wide_l ? hdr_full[7:4] : hdr_full[8:5];
   assign addr_full = wide_l ? {1'b0, hdr_full[3:0]} : hdr_full[4:0];
   assign data_full = {sh_q[14:0], din};
   assign data_len = wide_l ? DATA_BITS_WIDE : DATA_BITS_BYTE;
   assign hdr_last = link_state_q == LINK_HEAD && cnt_q == 5'h01;
   assign data_last = link_state_q == LINK_DATA && cnt_q == 5'h01;
   assign addr_nxt = wide_l ? {1'b0, addr_q[3:0] + 4'h1} :
                     addr_q + 5'h01;
   assign rd_addr = hdr_last ? addr_full : addr_nxt;
   // array is stable whenever busy reads low here
   assign rd_word = wide_l ?
      {mem_q[{rd_addr[3:0], 1'b1}], mem_q[{rd_addr[3:0], 1'b0}]} :
      {mem_q[rd_addr], 8'h00};

   always_comb begin
      cmd_op = OP_DISABLE;
      needs_data = 1'b0;
      is_read = 1'b0;
      case (op_full[3:2])
         OPC_READ: is_read = 1'b1;
         OPC_WRITE: begin
            cmd_op = OP_WRITE;
            needs_data = 1'b1;
         end
         OPC_ERASE: cmd_op = OP_ERASE;
         default: begin
            case (op_full)
               OPC_ENABLE: cmd_op = OP_ENABLE;
               OPC_CLEAR: cmd_op = OP_CLEAR_ALL;
               OPC_FILL: begin
                  cmd_op = OP_FILL_ALL;
                  needs_data = 1'b1;
               end
               default: cmd_op = OP_DISABLE;
            endcase
         end
      endcase
   end

   // dropped when busy or fifo full
   assign wr_valid = !busy_l2_q &&
      ((hdr_last && !is_read && !needs_data) || data_last);
   assign wr_cmd = '{op: data_last ? op_q : cmd_op,
                     wide: wide_l,
                     addr: data_last ? addr_q : addr_full,
                     data: data_full};

   // =====================================================================
   // link: sequencing, cleared by select low
   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         link_state_q <= LINK_IDLE;
         skip_q <= 1'b1;
         cnt_q <= 5'h00;
      end else begin
         skip_q <= 1'b0;
         case (link_state_q)
            LINK_IDLE: begin
               // first pulse ignored, then wait for a one
               if (!skip_q && din && !busy_l2_q) begin
                  link_state_q <= LINK_HEAD;
                  cnt_q <= wide_l ? HDR_BITS_WIDE : HDR_BITS_BYTE;
               end
            end
            LINK_HEAD: begin
               cnt_q <= cnt_q - 5'h01;
               if (cnt_q == 5'h01) begin
                  cnt_q <= data_len;
                  if (busy_l2_q) begin
                     link_state_q <= LINK_DONE;
                  end else if (is_read) begin
                     link_state_q <= LINK_READ;
                  end else if (needs_data) begin
                     link_state_q <= LINK_DATA;
                  end else begin
                     link_state_q <= LINK_DONE;
                  end
               end
            end
            LINK_DATA: begin
               cnt_q <= cnt_q - 5'h01;
               if (cnt_q == 5'h01) begin
                  link_state_q <= LINK_DONE;
               end
            end
            LINK_READ: begin
               cnt_q <= cnt_q - 5'h01;
               if (cnt_q == 5'h01) begin
                  cnt_q <= data_len;
               end
            end
            LINK_DONE: ;
            default: link_state_q <= LINK_IDLE;
         endcase
      end
   end

   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         sh_q <= 16'h0000;
      end else if ((hdr_last && is_read) ||
                   (link_state_q == LINK_READ && cnt_q == 5'h01)) begin
         sh_q <= rd_word;
      end else begin
         sh_q <= data_full;
      end
   end

   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         addr_q <= 5'h00;
         op_q <= OP_DISABLE;
      end else if (hdr_last) begin
         addr_q <= addr_full;
         op_q <= cmd_op;
      end else if (link_state_q == LINK_READ && cnt_q == 5'h01) begin
         addr_q <= addr_nxt;
      end
   end

   // =====================================================================
   // link: serial output
   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         q_out <= 1'b0;
      end else if (hdr_last && is_read && !busy_l2_q) begin
         q_out <= 1'b0;
      end else if (link_state_q == LINK_READ) begin
         q_out <= sh_q[15];
      end else begin
         q_out <= !busy_l2_q;
      end
   end

   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         q_oe <= 1'b0;
      end else begin
         q_oe <= 1'b1;
      end
   end
endmodule

`default_nettype wire

// ==== tb/eeprom_properties.sv ====
// Purpose: port-level properties of the eeprom access block
// Assumes: sel low clears the link side at once
// Notes: helper state follows sclk inside each frame
`timescale 1ns/1ps
`default_nettype none
module eeprom_properties
   import eeprom_pkg::*;
#(
   parameter int unsigned PROG_CYCLES_P = 20
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic sel,
   input wire logic din,
   input wire logic org_wide,
   input wire logic q_out,
   input wire logic q_oe
);
   // ==========
   // frame helpers
   logic [3:0] ecnt_q;
   logic [2:0] hist_q;
   logic tg_q;
   logic rd_hdr;
   // zero, start, then read op at edges 1 to 4
   assign rd_hdr = ecnt_q == 4'h3 && hist_q == 3'h3 && !din;
   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         ecnt_q <= 4'h0;
      end else if (ecnt_q != 4'hf) begin
         ecnt_q <= ecnt_q + 4'h1;
      end
   end
   always_ff @(posedge sclk or negedge sel) begin
      if (!sel) begin
         hist_q <= 3'h0;
         tg_q <= 1'b0;
      end else begin
         hist_q <= {hist_q[1:0], din};
         tg_q <= !tg_q;
      end
   end
   // ==========
   // properties
   property p_oe_off;
      @(posedge mclk) disable iff (reset) !sel |-> !q_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("q_oe high while deselected");
   property p_out_off;
      @(posedge mclk) disable iff (reset) !sel |-> !q_out;
   endproperty
   a_out_off: assert property (p_out_off)
      else $error("q_out high while deselected");
   property p_first_oe;
      @(posedge mclk) disable iff (reset)
         $rose(sel) && $stable(tg_q) |-> !q_oe;
   endproperty
   a_first_oe: assert property (p_first_oe)
      else $error("q_oe before first sclk edge");
   property p_oe_on;
      @(posedge sclk) disable iff (!sel) ecnt_q != 4'h0 |-> q_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("q_oe low inside frame");
   property p_hold_out;
      @(posedge mclk) disable iff (reset)
         sel && $past(sel) && $stable(tg_q) |-> $stable(q_out);
   endproperty
   a_hold_out: assert property (p_hold_out)
      else $error("q_out moved without sclk edge");
   property p_hold_oe;
      @(posedge mclk) disable iff (reset)
         sel && $past(sel) && $stable(tg_q) |-> $stable(q_oe);
   endproperty
   a_hold_oe: assert property (p_hold_oe)
      else $error("q_oe moved without sclk edge");
   property p_dummy16;
      @(posedge sclk) disable iff (!sel) rd_hdr && org_wide |-> ##7 !q_out;
   endproperty
   a_dummy16: assert property (p_dummy16)
      else $error("no dummy zero in x16 read");
   property p_dummy8;
      @(posedge sclk) disable iff (!sel) rd_hdr && !org_wide |-> ##8 !q_out;
   endproperty
   a_dummy8: assert property (p_dummy8)
      else $error("no dummy zero in x8 read");
   c_read16: cover property (@(posedge sclk) rd_hdr && org_wide);
   c_read8: cover property (@(posedge sclk) rd_hdr && !org_wide);
   c_frame: cover property (@(posedge mclk) $fell(sel));
endmodule

bind serial_eeprom_256bit_access eeprom_properties #(
   .PROG_CYCLES_P(PROG_CYCLES_P)
) u_props (
   .mclk(mclk), .reset(reset), .sclk(sclk), .sel(sel), .din(din),
   .org_wide(org_wide), .q_out(q_out), .q_oe(q_oe)
);
`default_nettype wire

// ==== tb/host_model.sv ====
// Purpose: host side of the serial link
// Assumes: sclk runs only inside frames, 80 ns period
// Notes: q_line floats while the block does not drive it
`timescale 1ns/1ps
`default_nettype none
module host_model (
   output logic sclk,
   output logic sel,
   output logic din,
   input wire logic q_out,
   input wire logic q_oe
);
   wire logic q_line;
   assign q_line = q_oe ? q_out : 1'bz;
   initial begin
      sclk = 1'b0;
      din = 1'b0;
      sel = 1'b1;
      // falling edge clears the link side at start
      #1 sel = 1'b0;
   end
   // n bits of b msb first, q sampled late in each period
   task automatic frame(input logic [63:0] b, input int n,
         output logic [63:0] got);
      got = '0;
      #7 sel <= 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         din <= b[i];
         // 80 ns period, the link logic has no minimum
         #40 sclk <= 1'b1;
         #40 sclk <= 1'b0;
         got = {got[62:0], q_line};
      end
      #40 sel <= 1'b0;
      din <= 1'b0;
      #300;
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the eeprom access block
// Assumes: programming shortened to 20 mclk cycles
// Notes: host model drives every frame
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      samples_checked++; \
      if ((a) !== (b)) begin \
         $display("BAD t=%0t got=%h exp=%h", $time, a, b); \
         fail_count++; \
      end \
   end
module testbench import eeprom_pkg::*;;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic org_wide = 1'b0;
   logic sclk, sel, din, q_out, q_oe;
   logic [63:0] got;
   int fail_count = 0;
   int samples_checked = 0;
   always #20 mclk = !mclk;
   serial_eeprom_256bit_access #(.PROG_CYCLES_P(20)) u_dut (
      .mclk(mclk), .reset(reset), .sclk(sclk), .sel(sel), .din(din),
      .org_wide(org_wide), .q_out(q_out), .q_oe(q_oe));
   host_model u_host (.sclk(sclk), .sel(sel), .din(din), .q_out(q_out),
      .q_oe(q_oe));
   // ==========
   // shared tasks
   task automatic send(input logic [3:0] op, input logic [4:0] a,
         input logic [15:0] d, input int nd, input int lead);
      int aw;
      logic [63:0] b;
      aw = org_wide ? 4 : 5;
      b = {60'h1, op};
      b = (((b << aw) | 64'(a)) << nd) | 64'(d);
      u_host.frame(b, lead + 5 + aw + nd, got);
   endtask
   task automatic rd(input logic [4:0] a, input int n,
         input logic [47:0] exp);
      int w;
      logic [47:0] m;
      w = org_wide ? 16 : 8;
      m = (48'h1 << (w * n)) - 48'h1;
      send({OPC_READ, 2'h0}, a, 16'h0, w * n, 1);
      `CHK(got[w * n], 1'b0)
      `CHK(got[47:0] & m, exp)
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 30; i++) begin
         u_host.frame(64'h0, 4, got);
         if (got[0] === 1'b1) break;
      end
      `CHK(got[0], 1'b1)
   endtask
   task automatic set_org(input logic v);
      @(posedge mclk) org_wide <= v;
      @(posedge mclk);
      // idle frame lets the link pick up the new level
      u_host.frame(64'h0, 4, got);
      `CHK(got[0], 1'b1)
   endtask
   // ==========
   // scenarios
   task automatic t_protect();
      send({OPC_WRITE, 2'h0}, 5'h04, 16'h00, 8, 1);
      wait_ready();
      rd(5'h04, 1, 48'hff);
   endtask
   task automatic t_write8();
      send(OPC_ENABLE, 5'h00, 16'h0, 0, 1);
      send({OPC_WRITE, 2'h0}, 5'h1f, 16'h5a, 8, 1);
      // start bit after status sync, must be ignored
      send({OPC_WRITE, 2'h0}, 5'h00, 16'h00, 8, 4);
      `CHK(got[18], 1'b0)
      wait_ready();
      rd(5'h1e, 3, 48'hff5aff);
   endtask
   task automatic t_word16();
      set_org(1'b1);
      send({OPC_WRITE, 2'h0}, 5'h0f, 16'ha55a, 16, 1);
      wait_ready();
      rd(5'h0f, 2, 48'ha55affff);
      send(OPC_FILL, 5'h00, 16'ha55a, 16, 1);
      wait_ready();
      rd(5'h00, 2, 48'ha55aa55a);
      set_org(1'b0);
      rd(5'h1e, 2, 48'h5aa5);
   endtask
   task automatic t_bulk();
      send({OPC_ERASE, 2'h0}, 5'h1f, 16'h0, 0, 1);
      wait_ready();
      rd(5'h1e, 2, 48'h5aff);
      send(OPC_FILL, 5'h00, 16'h3c, 8, 1);
      wait_ready();
      rd(5'h10, 2, 48'h3c3c);
      send({OPC_WRITE, 2'h0}, 5'h10, 16'hc3, 8, 1);
      wait_ready();
      rd(5'h10, 1, 48'hc3);
      send(OPC_CLEAR, 5'h00, 16'h0, 0, 1);
      wait_ready();
      rd(5'h10, 1, 48'hff);
      send(4'h0, 5'h00, 16'h0, 0, 1);
      send({OPC_WRITE, 2'h0}, 5'h00, 16'h11, 8, 1);
      wait_ready();
      rd(5'h00, 1, 48'hff);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #400_000;
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      t_protect();
      t_write8();
      t_word16();
      t_bulk();
      complete_run();
   end
endmodule
`default_nettype wire
